// file: rtl/hpm_cfg.svh
/*
 * hpm_cfg.svh: bit positions, reset values and pin indices for the host
 * port pin function mux.
 * Assumes it is included by bare name from rtl/ files only.
 */
`ifndef HPM_CFG_SVH
`define HPM_CFG_SVH

// port control register fields (16 bits)
`define HPM_CTL_WIDTH 16
`define HPM_CTL_GPIO_EN 0
`define HPM_CTL_HOST_EN 1
`define HPM_CTL_MUXED 2
`define HPM_CTL_DBL_STROBE 3
`define HPM_CTL_AS_POL 4
`define HPM_CTL_DS_POL 5
`define HPM_CTL_RD_POL 6
`define HPM_CTL_WR_POL 7
`define HPM_CTL_RESET 16'h0000

// pin counts and pin indices within the 13 shared lines
`define HPM_NPINS 13
`define HPM_PIN_A0 8
`define HPM_PIN_A1 9
`define HPM_PIN_A2 10
`define HPM_PIN_RW 11
`define HPM_PIN_DS 12
`define HPM_DDR_RESET 13'h0000

`endif

// file: rtl/hpm_pkg.sv
/*
 * hpm_pkg.sv: device mode type and host access state type for the two ends of the host port pin mux.
 * Assumes hpm_cfg.svh is on the include path.
 */
`include "hpm_cfg.svh"

package hpm_pkg;
    typedef enum logic [1:0] {
        HPM_MODE_OFF,
        HPM_MODE_GPIO,
        HPM_MODE_PLAIN,
        HPM_MODE_MUXED
    } hpm_mode_t;

    typedef enum logic [1:0] {
        HPM_HIDLE,
        HPM_HADDR,
        HPM_HSTROBE,
        HPM_HDONE
    } hpm_hstate_t;
endpackage : hpm_pkg

// file: rtl/hpm_if.sv
/*
 * hpm_if.sv: the 13 shared host port lines between the signal processor
 * end and the external host end.
 * Assumes the bench resolves each wire level from the two enables.
 */
`timescale 1ns/1ps
`include "hpm_cfg.svh"

interface hpm_if;
    logic [`HPM_NPINS-1:0] dev_out;
    logic [`HPM_NPINS-1:0] dev_oe;
    logic [`HPM_NPINS-1:0] host_out;
    logic [`HPM_NPINS-1:0] host_oe;
    logic [`HPM_NPINS-1:0] pin_in;

    modport dev (
        output dev_out,
        output dev_oe,
        input pin_in
    );
    modport host (
        output host_out,
        output host_oe,
        input pin_in
    );
endinterface : hpm_if

// file: rtl/hpm_dev.sv
/*
 * hpm_dev.sv: signal processor end of the host port. Decodes the port
 * control register into per-pin functions, drives the data lines in
 * host mode, the gpio lines in port mode, and presents normalised
 * active-high strobes and address bits to the core.
 * Assumes pins are synchronous to mclk; core writes control words
 * through plain write-enable ports.
 */
// Behaviour
// - control register alone chooses pin functions
// - plain host mode: tri-state data bits 0-7
// - muxed host mode: address/data bits 0-7 tri-state
// - gpio mode: direction register sets each pin
// - plain mode: three pins give address bits 0-2
// - muxed mode: address strobe, programmable polarity
// - muxed mode: address pins carry bits 8, 9
// - single strobe: read/write select input from host
// - single strobe: data strobe, programmable polarity
// - double strobe: read strobe, programmable polarity
// - double strobe: write strobe, programmable polarity
`timescale 1ns/1ps
`include "hpm_cfg.svh"

module hpm_dev
    import hpm_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    hpm_if.dev pins,
    input wire logic ctl_we,
    input wire logic [`HPM_CTL_WIDTH-1:0] ctl_wdata,
    input wire logic ddr_we,
    input wire logic [`HPM_NPINS-1:0] ddr_wdata,
    input wire logic gpo_we,
    input wire logic [`HPM_NPINS-1:0] gpo_wdata,
    input wire logic [7:0] core_data_out,
    input wire logic core_data_oe,
    output logic [`HPM_CTL_WIDTH-1:0] ctl_rdata,
    output logic [`HPM_NPINS-1:0] gpio_in,
    output logic [7:0] host_data_in,
    output logic [2:0] host_addr_low,
    output logic [1:0] host_addr_high,
    output logic host_addr_strobe,
    output logic host_read_write_sel,
    output logic host_data_strobe_in,
    output logic host_read_strobe,
    output logic host_write_strobe,
    output hpm_mode_t mode
);
    logic [`HPM_CTL_WIDTH-1:0] port_control_reg;
    logic [`HPM_NPINS-1:0] gpio_direction_reg;
    logic [`HPM_NPINS-1:0] gpo_reg;
    logic [`HPM_NPINS-1:0] out_reg;
    logic [`HPM_NPINS-1:0] oe_reg;
    hpm_mode_t mode_next;
    logic host_sel;
    logic as_pol, ds_pol, rd_pol, wr_pol, dbl;

    assign pins.dev_out = out_reg;
    assign pins.dev_oe = oe_reg;

    // control word: the only source of pin functions
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            port_control_reg <= `HPM_CTL_RESET;
        end else if (ctl_we) begin
            port_control_reg <= ctl_wdata;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gpio_direction_reg <= `HPM_DDR_RESET;
        end else if (ddr_we) begin
            gpio_direction_reg <= ddr_wdata;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gpo_reg <= `HPM_DDR_RESET;
        end else if (gpo_we) begin
            gpo_reg <= gpo_wdata;
        end
    end

    // host function wins if both enables are set
    always_comb begin
        if (port_control_reg[`HPM_CTL_HOST_EN]) begin
            mode_next = port_control_reg[`HPM_CTL_MUXED] ?
                HPM_MODE_MUXED : HPM_MODE_PLAIN;
        end else if (port_control_reg[`HPM_CTL_GPIO_EN]) begin
            mode_next = HPM_MODE_GPIO;
        end else begin
            mode_next = HPM_MODE_OFF;
        end
    end

    assign dbl = port_control_reg[`HPM_CTL_DBL_STROBE];
    // polarity bit clear means active low, so the reset value gives low
    assign as_pol = port_control_reg[`HPM_CTL_AS_POL];
    assign ds_pol = port_control_reg[`HPM_CTL_DS_POL];
    assign rd_pol = port_control_reg[`HPM_CTL_RD_POL];
    assign wr_pol = port_control_reg[`HPM_CTL_WR_POL];
    assign host_sel = (mode_next == HPM_MODE_PLAIN) ||
        (mode_next == HPM_MODE_MUXED);

    // pin drivers: registered so no output glitches on mode changes
    // the core owns the data drive; a clash with the host is not caught
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            out_reg <= '0;
            oe_reg <= '0;
        end else begin
            unique case (mode_next)
                HPM_MODE_GPIO: begin
                    out_reg <= gpo_reg;
                    oe_reg <= gpio_direction_reg;
                end
                HPM_MODE_PLAIN, HPM_MODE_MUXED: begin
                    // same drive for both; core_data_oe alone keeps the muxed address phase input
                    out_reg <= {5'h00, core_data_out};
                    oe_reg <= {5'h00, {8{core_data_oe}}};
                end
                HPM_MODE_OFF: begin
                    out_reg <= '0;
                    oe_reg <= '0;
                end
            endcase
        end
    end

    // inputs toward the core, decoded by the mode now in force
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mode <= HPM_MODE_OFF;
            ctl_rdata <= `HPM_CTL_RESET;
        end else begin
            mode <= mode_next;
            ctl_rdata <= port_control_reg;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gpio_in <= '0;
        end else begin
            gpio_in <= (mode_next == HPM_MODE_GPIO) ?
                pins.pin_in : '0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            host_data_in <= 8'h00;
        end else begin
            host_data_in <= host_sel ? pins.pin_in[7:0] : 8'h00;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            host_addr_low <= 3'h0;
            host_addr_high <= 2'h0;
        end else begin
            host_addr_low <= (mode_next == HPM_MODE_PLAIN) ?
                {pins.pin_in[`HPM_PIN_A2], pins.pin_in[`HPM_PIN_A1],
                 pins.pin_in[`HPM_PIN_A0]} : 3'h0;
            host_addr_high <= (mode_next == HPM_MODE_MUXED) ?
                {pins.pin_in[`HPM_PIN_A2],
                 pins.pin_in[`HPM_PIN_A1]} : 2'h0;
        end
    end

    // strobes leave here active high whatever the pin polarity
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            host_addr_strobe <= 1'b0;
        end else begin
            host_addr_strobe <= (mode_next == HPM_MODE_MUXED) &&
                (pins.pin_in[`HPM_PIN_A0] == as_pol);
        end
    end

    // single strobe: direction level plus one data strobe
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            host_read_write_sel <= 1'b0;
            host_data_strobe_in <= 1'b0;
        end else begin
            host_read_write_sel <= host_sel && !dbl &&
                pins.pin_in[`HPM_PIN_RW];
            host_data_strobe_in <= host_sel && !dbl &&
                (pins.pin_in[`HPM_PIN_DS] == ds_pol);
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            host_read_strobe <= 1'b0;
            host_write_strobe <= 1'b0;
        end else begin
            host_read_strobe <= host_sel && dbl &&
                (pins.pin_in[`HPM_PIN_RW] == rd_pol);
            host_write_strobe <= host_sel && dbl &&
                (pins.pin_in[`HPM_PIN_DS] == wr_pol);
        end
    end
endmodule : hpm_dev

// file: rtl/hpm_host.sv
/*
 * hpm_host.sv: external host end. Runs one strobed access on request,
 * in plain or muxed bus form, single or double strobe, with the strobe
 * polarities it is told. Each phase lasts one mclk cycle.
 * Assumes the configuration inputs match the device's control register.
 */
`timescale 1ns/1ps
`include "hpm_cfg.svh"

module hpm_host
    import hpm_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    hpm_if.host pins,
    input wire logic cfg_muxed,
    input wire logic cfg_dbl,
    input wire logic cfg_as_pol,
    input wire logic cfg_ds_pol,
    input wire logic req,
    input wire logic req_write,
    input wire logic [9:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic busy,
    output logic done,
    output logic [7:0] rdata
);
    hpm_hstate_t state;
    logic [`HPM_NPINS-1:0] out_reg;
    logic [`HPM_NPINS-1:0] oe_reg;
    logic wr_reg;
    logic [9:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [`HPM_NPINS-1:0] base;

    assign pins.host_out = out_reg;
    assign pins.host_oe = oe_reg;

    // idle levels: all strobes inactive, address pins carry the address
    always_comb begin
        base = '0;
        base[`HPM_PIN_DS] = !cfg_ds_pol;
        base[`HPM_PIN_RW] = cfg_dbl ? !cfg_ds_pol : !wr_reg;
        if (cfg_muxed) begin
            base[`HPM_PIN_A0] = !cfg_as_pol;
            base[`HPM_PIN_A1] = addr_reg[8];
            base[`HPM_PIN_A2] = addr_reg[9];
        end else begin
            base[`HPM_PIN_A0] = addr_reg[0];
            base[`HPM_PIN_A1] = addr_reg[1];
            base[`HPM_PIN_A2] = addr_reg[2];
        end
        if (wr_reg) begin
            base[7:0] = wdata_reg;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= HPM_HIDLE;
            wr_reg <= 1'b0;
            addr_reg <= 10'h000;
            wdata_reg <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
        end else begin
            done <= 1'b0;
            unique case (state)
                HPM_HIDLE: begin
                    if (req) begin
                        wr_reg <= req_write;
                        addr_reg <= req_addr;
                        wdata_reg <= req_wdata;
                        busy <= 1'b1;
                        state <= cfg_muxed ? HPM_HADDR : HPM_HSTROBE;
                    end
                end
                HPM_HADDR: state <= HPM_HSTROBE;
                HPM_HSTROBE: state <= HPM_HDONE;
                HPM_HDONE: begin
                    // pins now show the strobe cycle that just ended
                    if (!wr_reg) begin
                        rdata <= pins.pin_in[7:0];
                    end
                    busy <= 1'b0;
                    done <= 1'b1;
                    state <= HPM_HIDLE;
                end
            endcase
        end
    end

    // pins show each phase one cycle after its state is entered
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            out_reg <= '0;
            oe_reg <= '0;
        end else begin
            out_reg <= base;
            oe_reg <= {5'h1f, {8{wr_reg}}};
            if (state == HPM_HADDR) begin
                out_reg[7:0] <= addr_reg[7:0];
                oe_reg[7:0] <= 8'hff;
                out_reg[`HPM_PIN_A0] <= cfg_as_pol;
            end else if (state == HPM_HSTROBE) begin
                if (cfg_dbl && !wr_reg) begin
                    out_reg[`HPM_PIN_RW] <= cfg_ds_pol;
                end else begin
                    out_reg[`HPM_PIN_DS] <= cfg_ds_pol;
                end
            end else if (state == HPM_HIDLE) begin
                oe_reg <= '0;
            end
        end
    end
endmodule : hpm_host

// file: bench/hpm_monitor.sv
/* hpm_monitor.sv: concurrent checks on the shared host port lines and
   the device decode outputs.
   Assumes one mclk domain, nrst async active low, bench-resolved lines. */
`timescale 1ns/1ps
module hpm_monitor
    import hpm_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [12:0] dev_oe,
    input wire logic [12:0] host_oe,
    input wire logic [12:0] pin_in,
    input wire logic [15:0] ctl_rdata,
    input wire hpm_mode_t mode,
    input wire logic [2:0] host_addr_low,
    input wire logic [1:0] host_addr_high,
    input wire logic host_addr_strobe,
    input wire logic host_read_write_sel,
    input wire logic host_data_strobe_in,
    input wire logic host_read_strobe,
    input wire logic host_write_strobe
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    logic hst;
    logic dbl;
    assign hst = mode == HPM_MODE_PLAIN || mode == HPM_MODE_MUXED;
    assign dbl = ctl_rdata[3];
    a_reset_quiet: assert property ($rose(nrst) |-> dev_oe == 13'h0000
        && host_oe == 13'h0000) else $error("drive after reset");
    a_mode_decode: assert property (mode == (ctl_rdata[1] ?
        (ctl_rdata[2] ? HPM_MODE_MUXED : HPM_MODE_PLAIN) :
        (ctl_rdata[0] ? HPM_MODE_GPIO : HPM_MODE_OFF)))
        else $error("mode not from control word");
    a_off_no_drive: assert property (mode == HPM_MODE_OFF
        |-> dev_oe == 13'h0000) else $error("drive while off");
    a_host_bus_wide: assert property (hst |->
        dev_oe[12:8] == 5'h00 &&
        (dev_oe[7:0] == 8'h00 || dev_oe[7:0] == 8'hff))
        else $error("host mode pin drive");
    a_plain_addr: assert property (mode == HPM_MODE_PLAIN
        |-> host_addr_low == $past(pin_in[10:8])) else $error("addr low");
    a_muxed_addr: assert property (mode == HPM_MODE_MUXED |->
        host_addr_high == $past(pin_in[10:9]) && host_addr_strobe ==
        ($past(pin_in[8]) == ctl_rdata[4]))
        else $error("muxed addr or strobe");
    a_ds_norm: assert property (hst && !dbl |->
        host_data_strobe_in == ($past(pin_in[12]) == ctl_rdata[5]) &&
        host_read_write_sel == $past(pin_in[11])) else $error("data strobe");
    a_rd_norm: assert property (hst && dbl |->
        host_read_strobe == ($past(pin_in[11]) == ctl_rdata[6]))
        else $error("rd strobe");
    a_wr_norm: assert property (hst && dbl |->
        host_write_strobe == ($past(pin_in[12]) == ctl_rdata[7]))
        else $error("wr strobe");
    a_strobe_qual: assert property (!(hst && dbl) |->
        !host_read_strobe && !host_write_strobe)
        else $error("double strobe out of mode");
    c_addr_strobe: cover property (host_addr_strobe);
    c_rd_strobe: cover property (host_read_strobe);
    c_wr_strobe: cover property (host_write_strobe);
    c_gpio: cover property (mode == HPM_MODE_GPIO);
endmodule : hpm_monitor

// file: bench/tb_hpm.sv
/* tb_hpm.sv: self-checking bench joining device end and host end.
   Assumes lines resolve here: device, then host, then bench far side;
   an undriven line toggles each cycle as no pull exists. */
`timescale 1ns/1ps
module tb_hpm;
    import hpm_pkg::*;
    logic mclk = 0, nrst = 0, ctl_we = 0, ddr_we = 0, gpo_we = 0;
    logic core_data_oe = 0, req = 0, req_write = 0, busy, done;
    logic cfg_muxed = 0, cfg_dbl = 0, cfg_as_pol = 0, cfg_ds_pol = 0;
    logic [15:0] ctl_wdata = 16'h0000, ctl_rdata;
    logic [12:0] ddr_wdata = 13'h0000, gpo_wdata = 13'h0000, gpio_in;
    logic [12:0] ext_oe = 13'h0000, ext_val = 13'h0000;
    logic [7:0] core_data_out = 8'h00, req_wdata = 8'h00, rdata;
    logic [7:0] host_data_in;
    logic [9:0] req_addr = 10'h000;
    logic [2:0] host_addr_low;
    logic [1:0] host_addr_high;
    logic host_addr_strobe, host_read_write_sel, host_data_strobe_in;
    logic host_read_strobe, host_write_strobe;
    hpm_mode_t mode;
    int err_count = 0, tests_run = 0, cyc = 0;
    hpm_if u_if();
    hpm_dev u_hpm_dev(.mclk, .nrst, .pins(u_if), .ctl_we, .ctl_wdata,
        .ddr_we, .ddr_wdata, .gpo_we, .gpo_wdata, .core_data_out,
        .core_data_oe, .ctl_rdata, .gpio_in, .host_data_in, .host_addr_low,
        .host_addr_high, .host_addr_strobe, .host_read_write_sel,
        .host_data_strobe_in, .host_read_strobe, .host_write_strobe, .mode);
    hpm_host u_hpm_host(.mclk, .nrst, .pins(u_if), .cfg_muxed, .cfg_dbl,
        .cfg_as_pol, .cfg_ds_pol, .req, .req_write, .req_addr, .req_wdata,
        .busy, .done, .rdata);
    hpm_monitor u_hpm_monitor(.mclk, .nrst, .dev_oe(u_if.dev_oe),
        .host_oe(u_if.host_oe), .pin_in(u_if.pin_in), .ctl_rdata, .mode,
        .host_addr_low, .host_addr_high, .host_addr_strobe,
        .host_read_write_sel, .host_data_strobe_in, .host_read_strobe,
        .host_write_strobe);
    always #50 mclk = ~mclk;
    always_comb begin
        for (int i = 0; i < 13; i++) begin
            u_if.pin_in[i] = cyc[0] ^ i[0];
            if (ext_oe[i])
                u_if.pin_in[i] = ext_val[i];
            if (u_if.host_oe[i])
                u_if.pin_in[i] = u_if.host_out[i];
            if (u_if.dev_oe[i])
                u_if.pin_in[i] = u_if.dev_out[i];
        end
    end
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    // ceiling far above the roughly 230 cycles the sequence needs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic cfg(input logic [15:0] c, input logic [12:0] d);
        ctl_we <= 1'b1;
        ctl_wdata <= c;
        ddr_we <= 1'b1;
        ddr_wdata <= d;
        @(posedge mclk);
        ctl_we <= 1'b0;
        ddr_we <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : cfg
    task automatic t_gpio;
        cfg(16'h0001, 13'h0f0f);
        gpo_we <= 1'b1;
        gpo_wdata <= 13'h1555;
        ext_oe <= 13'h10f0;
        ext_val <= 13'h0aa0;
        @(posedge mclk);
        gpo_we <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check(u_if.dev_oe === 13'h0f0f, "gpio direction");
        check((u_if.dev_out & 13'h0f0f) === 13'h0505, "gpio out");
        check((gpio_in & 13'h10f0) === 13'h00a0, "gpio in");
        $display("test gpio done");
    endtask : t_gpio
    task automatic t_access(input logic mx, db, pl, wr, input logic [9:0] a,
                            input logic [7:0] d);
        logic seen_as, seen_st, seen_done;
        logic [7:0] got;
        logic [1:0] hi;
        logic [2:0] lo;
        seen_as = 0;
        seen_st = 0;
        seen_done = 0;
        @(posedge mclk);
        // strobe lines rest inactive between accesses, as a board pull would
        ext_oe <= 13'h1f00;
        ext_val <= {{5{~pl}}, 8'h00};
        {cfg_muxed, cfg_dbl, cfg_as_pol, cfg_ds_pol} <= {mx, db, pl, pl};
        core_data_out <= d;
        core_data_oe <= !wr && !mx;
        cfg({8'h00, {4{pl}}, db, mx, 2'b10}, 13'h0000);
        req <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        @(posedge mclk);
        req <= 1'b0;
        // muxed: core waits out the host's address phase to avoid a clash
        if (mx)
            @(posedge mclk);
        core_data_oe <= !wr;
        for (int n = 0; n < 8; n++) begin
            @(posedge mclk);
            #1;
            seen_done |= done === 1'b1;
            if (host_addr_strobe === 1'b1) begin
                seen_as = 1;
                hi = host_addr_high;
            end
            if ((db ? (wr ? host_write_strobe : host_read_strobe)
                    : host_data_strobe_in) === 1'b1) begin
                seen_st = 1;
                got = host_data_in;
                lo = host_addr_low;
            end
        end
        core_data_oe <= 1'b0;
        check(seen_done && seen_st, "strobe");
        if (wr)
            check(got === d, "write data");
        else
            check(rdata === d, "read data");
        if (mx)
            check(seen_as && hi === a[9:8], "addr high");
        else
            check(lo === a[2:0], "addr low");
        $display("test access %b%b%b%b done", mx, db, pl, wr);
    endtask : t_access
    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        #1;
        check(ctl_rdata === 16'h0000 && mode === HPM_MODE_OFF,
              "reset");
        @(posedge mclk);
        t_gpio();
        for (int k = 0; k < 16; k++)
            t_access(k[3], k[2], k[1], k[0], {k[1:0], 5'h0a, k[3:1]},
                     {4'h5, k[3:0]});
        stop_test();
    end
endmodule : tb_hpm
